// *** include/deb_pkg.sv ***
// package: object indices, field layout, reset values and abort codes of the error object bank
package deb_pkg;

	// ----------------------------------------------------------------
	// object addressing: address = {index[15:0], subindex[7:0]}
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 24;
	localparam logic [15:0] IDX_IDENT       = 16'h1000;
	localparam logic [15:0] IDX_SUMMARY     = 16'h1001;
	localparam logic [15:0] IDX_STACK       = 16'h1003;
	localparam logic [15:0] IDX_IRQ_STATUS  = 16'h2000;
	localparam logic [15:0] IDX_IRQ_MASK    = 16'h2001;
	localparam logic [7:0]  SUB_COUNT       = 8'h00;
	localparam logic [7:0]  SUB_FIRST       = 8'h01;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int          ID_MOTOR_LSB    = 16;
	localparam int          ENT_NUMBER_LSB  = 24;
	localparam int          ENT_CLASS_LSB   = 16;
	localparam int          SUM_GENERAL     = 0;
	localparam int          SUM_CURRENT     = 1;
	localparam int          SUM_VOLTAGE     = 2;
	localparam int          SUM_TEMP        = 3;
	localparam int          SUM_LINK        = 4;
	localparam int          SUM_PROFILE     = 5;
	localparam int          SUM_SPARE       = 6;
	localparam int          SUM_VENDOR      = 7;
	localparam logic [7:0]  SUM_USED_MASK   = 8'hBF;
	localparam int          IRQ_NEW_ERROR   = 0;
	localparam int          IRQ_DISCARD     = 1;
	localparam int          IRQ_SUMMARY     = 2;
	localparam int          IRQ_W           = 3;

	// ----------------------------------------------------------------
	// reset values, motor type codes and abort codes
	// ----------------------------------------------------------------
	localparam logic [7:0]  SUMMARY_RESET   = 8'h00;
	localparam logic [7:0]  COUNT_RESET     = 8'h00;
	localparam logic [31:0] ENTRY_RESET     = 32'h00000000;
	localparam logic [7:0]  COUNT_MAX       = 8'hFF;
	localparam logic [7:0]  MOTOR_BLDC      = 8'h02;
	localparam logic [7:0]  MOTOR_STEPPER   = 8'h04;
	localparam logic [7:0]  MOTOR_BOTH      = 8'h06;
	localparam logic [31:0] ABORT_EMPTY     = 32'h08000024;
	localparam logic [31:0] ABORT_READ_ONLY = 32'h0000A001;
	localparam logic [31:0] ABORT_NO_OBJECT = 32'h0000A002;
	localparam logic [31:0] ABORT_BAD_VALUE = 32'h0000A003;

	// packs one history entry: number, class, code
	function automatic logic [31:0] deb_pack_entry(input logic [7:0] num, input logic [7:0] cls,
		input logic [15:0] code);
		deb_pack_entry = {num, cls, code};
	endfunction : deb_pack_entry

	// true when address selects a given object index
	function automatic logic deb_is_index(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
		deb_is_index = (a[23:8] == idx);
	endfunction : deb_is_index

endpackage : deb_pkg

// *** rtl/deb_stack.sv ***
// error history stack: newest entry on top, older entries shift down
`timescale 1ns/100ps
module deb_stack
	import deb_pkg::*;
#(
	parameter int DEPTH = 8
) (
	input  wire logic                       mclk,
	input  wire logic                       srst,
	input  wire logic                       ce,
	input  wire logic                       push,
	input  wire logic [31:0]                entry_in,
	input  wire logic [$clog2(DEPTH)-1:0]   rd_pos,
	output logic      [31:0]                rd_entry
);

	// refused at elaboration: the position must fit the 8-bit subindex
	if (DEPTH < 2 || DEPTH > 255) begin : g_bad_depth
		$error("deb_stack: DEPTH out of range");
	end

	logic [31:0] entry [DEPTH];

	// ----------------------------------------------------------------
	// shift on push; the oldest entry falls off the bottom
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int i = 0; i < DEPTH; i++) begin
				entry[i] <= ENTRY_RESET;
			end
		end else if (ce && push) begin
			entry[0] <= entry_in;
			for (int i = 1; i < DEPTH; i++) begin
				entry[i] <= entry[i-1];
			end
		end
	end

	// position 0 of rd_pos is history entry 1
	assign rd_entry = entry[rd_pos];

	chk_push_top: assert property (@(posedge mclk) disable iff (srst)
		(ce && push) |=> (entry[0] == $past(entry_in)))
		else $error("new entry not on top");

	chk_push_shift: assert property (@(posedge mclk) disable iff (srst)
		(ce && push) |=> (entry[1] == $past(entry[0])) && (entry[DEPTH-1] == $past(entry[DEPTH-2])))
		else $error("stack did not shift down");

	chk_hold_still: assert property (@(posedge mclk) disable iff (srst)
		!(ce && push) |=> $stable(entry[0]) && $stable(entry[DEPTH-1]))
		else $error("stack changed without a push");

endmodule : deb_stack

// *** rtl/deb_bank.sv ***
// error object bank: identification word, error summary, error history and interrupt registers
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
// Overview of operation
// - read-only 32-bit identification word, controller type
// - upper half holds motor type code
// - lower 16 bits hold drive profile number
// - read-only 8-bit summary, one bit per class
// - summary bit clears itself when fault gone
// - eight read-only 32-bit history entries, reset zero
// - position zero is read/write 8-bit count
// - entries addressed 1 to 8, newest first
// - new error enters top, older entries shift
// - entry read on empty stack aborts 08000024h
// - writing zero to count restarts counting
// - entry packs number, class and code
module deb_bank
	import deb_pkg::*;
#(
	parameter logic [7:0]  MOTOR_TYPE     = MOTOR_BOTH,
	// arbitrary neutral profile number
	parameter logic [15:0] PROFILE_NUMBER = 16'h0ABC,
	parameter int          DEPTH          = 8
) (
	input  wire logic                mclk,
	input  wire logic                srst,
	input  wire logic                ce,
	input  wire logic [ADDR_W-1:0]   addr,
	input  wire logic [31:0]         wdata,
	input  wire logic                wr,
	input  wire logic                rd,
	output logic      [31:0]         rdata,
	output logic                     resp_abort,
	output logic      [31:0]         abort_code,
	input  wire logic [7:0]          fault_active,
	input  wire logic                err_push,
	input  wire logic [7:0]          err_number,
	input  wire logic [7:0]          err_class,
	input  wire logic [15:0]         err_code,
	output logic      [7:0]          error_summary,
	output logic                     irq
);

	localparam int POS_W = $clog2(DEPTH);

	// refused at elaboration: unknown motor code or a depth the subindex cannot reach
	if (MOTOR_TYPE != MOTOR_BLDC && MOTOR_TYPE != MOTOR_STEPPER && MOTOR_TYPE != MOTOR_BOTH) begin : g_bad_motor
		$error("deb_bank: MOTOR_TYPE must be a documented motor code");
	end
	if (DEPTH < 2 || DEPTH > 255) begin : g_bad_depth
		$error("deb_bank: DEPTH out of range");
	end

	// ----------------------------------------------------------------
	// identification word
	// ----------------------------------------------------------------
	logic [31:0] ident_word;

	// upper byte of the motor half is fixed zero
	assign ident_word = {8'h00, MOTOR_TYPE, PROFILE_NUMBER};

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	logic        sel_ident;
	logic        sel_summary;
	logic        sel_count;
	logic        sel_entry;
	logic        sel_status;
	logic        sel_mask;
	logic [7:0]  sub;
	logic [POS_W-1:0] entry_pos;

	assign sub         = addr[7:0];
	assign sel_ident   = deb_is_index(addr, IDX_IDENT) && sub == SUB_COUNT;
	assign sel_summary = deb_is_index(addr, IDX_SUMMARY) && sub == SUB_COUNT;
	assign sel_count   = deb_is_index(addr, IDX_STACK) && sub == SUB_COUNT;
	assign sel_entry   = deb_is_index(addr, IDX_STACK) && sub >= SUB_FIRST && sub <= 8'(DEPTH);
	assign sel_status  = deb_is_index(addr, IDX_IRQ_STATUS) && sub == SUB_COUNT;
	assign sel_mask    = deb_is_index(addr, IDX_IRQ_MASK) && sub == SUB_COUNT;
	assign entry_pos   = POS_W'(sub - SUB_FIRST);

	// ----------------------------------------------------------------
	// error summary
	// ----------------------------------------------------------------
	// fault_active comes from logic on mclk, so no synchroniser; the summary
	// is a live view, so a fault shorter than one cycle may never show
	always_ff @(posedge mclk) begin
		if (srst) begin
			error_summary <= SUMMARY_RESET;
		end else if (ce) begin
			error_summary <= fault_active & SUM_USED_MASK;
		end
	end

	// ----------------------------------------------------------------
	// history stack and error count
	// ----------------------------------------------------------------
	logic [31:0] new_entry;
	logic [31:0] stack_entry;
	logic [7:0]  error_count;
	logic [7:0]  next_error_count;
	logic        count_zero_wr;
	logic        stack_empty;

	assign new_entry     = deb_pack_entry(err_number, err_class, err_code);
	assign count_zero_wr = wr && sel_count && wdata[7:0] == 8'h00 && wdata[31:8] == 24'h000000;
	assign stack_empty   = (error_count == COUNT_RESET);

	deb_stack #(
		.DEPTH    (DEPTH)
	) u_stack (
		.mclk     (mclk),
		.srst     (srst),
		.ce       (ce),
		.push     (err_push),
		.entry_in (new_entry),
		.rd_pos   (entry_pos),
		.rd_entry (stack_entry)
	);

	// a push in the same cycle as a zero write still counts: the restarted
	// count starts at one so the fresh error stays readable
	always_comb begin
		next_error_count = error_count;
		if (count_zero_wr) begin
			next_error_count = COUNT_RESET;
		end
		if (err_push) begin
			if (count_zero_wr) begin
				next_error_count = 8'h01;
			end else if (error_count != COUNT_MAX) begin
				next_error_count = error_count + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			error_count <= COUNT_RESET;
		end else if (ce) begin
			error_count <= next_error_count;
		end
	end

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_event;
	logic [7:0]       summary_prev;

	always_ff @(posedge mclk) begin
		if (srst) begin
			summary_prev <= SUMMARY_RESET;
		end else if (ce) begin
			summary_prev <= error_summary;
		end
	end

	always_comb begin
		irq_event                = '0;
		irq_event[IRQ_NEW_ERROR] = err_push;
		irq_event[IRQ_DISCARD]   = err_push && !count_zero_wr && error_count >= 8'(DEPTH);
		irq_event[IRQ_SUMMARY]   = |(error_summary & ~summary_prev);
	end

	// write one to clear; a new event in the same cycle wins
	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_status <= '0;
		end else if (ce) begin
			irq_status <= (irq_status & ~((wr && sel_status) ? wdata[IRQ_W-1:0] : '0)) | irq_event;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_mask <= '0;
		end else if (ce && wr && sel_mask) begin
			irq_mask <= wdata[IRQ_W-1:0];
		end
	end

	assign irq = |(irq_status & irq_mask);

	// ----------------------------------------------------------------
	// read and write answers
	// ----------------------------------------------------------------
	logic        next_abort;
	logic [31:0] next_code;
	logic [31:0] next_rdata;

	always_comb begin
		next_abort = 1'b0;
		next_code  = 32'h00000000;
		next_rdata = 32'h00000000;
		if (rd) begin
			if (sel_ident) begin
				next_rdata = ident_word;
			end else if (sel_summary) begin
				next_rdata = {24'h000000, error_summary};
			end else if (sel_count) begin
				next_rdata = {24'h000000, error_count};
			end else if (sel_entry) begin
				if (stack_empty) begin
					next_abort = 1'b1;
					next_code  = ABORT_EMPTY;
				end else begin
					next_rdata = stack_entry;
				end
			end else if (sel_status) begin
				next_rdata = {{(32-IRQ_W){1'b0}}, irq_status};
			end else if (sel_mask) begin
				next_rdata = {{(32-IRQ_W){1'b0}}, irq_mask};
			end else begin
				next_abort = 1'b1;
				next_code  = ABORT_NO_OBJECT;
			end
		end else if (wr) begin
			if (sel_ident || sel_summary || sel_entry) begin
				next_abort = 1'b1;
				next_code  = ABORT_READ_ONLY;
			end else if (sel_count) begin
				// only zero may be written to the count
				if (!count_zero_wr) begin
					next_abort = 1'b1;
					next_code  = ABORT_BAD_VALUE;
				end
			end else if (!sel_status && !sel_mask) begin
				next_abort = 1'b1;
				next_code  = ABORT_NO_OBJECT;
			end
		end
	end

	// answers stand for one cycle only
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata      <= 32'h00000000;
			resp_abort <= 1'b0;
			abort_code <= 32'h00000000;
		end else if (ce) begin
			rdata      <= next_rdata;
			resp_abort <= next_abort;
			abort_code <= next_code;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_ident_read: assert property (@(posedge mclk) disable iff (srst)
		(ce && rd && sel_ident) |=> (rdata[31:24] == 8'h00) && (rdata[23:16] == MOTOR_TYPE)
			&& (rdata[15:0] == PROFILE_NUMBER) && !resp_abort)
		else $error("identification word read wrong");

	chk_summary_follow: assert property (@(posedge mclk) disable iff (srst)
		(ce && fault_active[SUM_GENERAL]) ##1 (ce && !fault_active[SUM_GENERAL])
			|=> !error_summary[SUM_GENERAL])
		else $error("summary bit did not clear with its fault");

	chk_summary_set: assert property (@(posedge mclk) disable iff (srst)
		ce |=> (error_summary == ($past(fault_active) & SUM_USED_MASK)) && !error_summary[SUM_SPARE])
		else $error("summary does not follow fault classes");

	chk_count_step: assert property (@(posedge mclk) disable iff (srst)
		(ce && err_push && !(wr && sel_count) && error_count != COUNT_MAX)
			|=> error_count == $past(error_count) + 8'h01)
		else $error("count did not step on a new error");

	chk_count_clear: assert property (@(posedge mclk) disable iff (srst)
		(ce && count_zero_wr && !err_push) |=> (error_count == COUNT_RESET) && stack_empty
			&& !resp_abort && rdata == 32'h00000000)
		else $error("zero write did not restart count");

	chk_empty_abort: assert property (@(posedge mclk) disable iff (srst)
		(ce && rd && sel_entry && stack_empty) |=> resp_abort && abort_code == ABORT_EMPTY
			&& rdata == 32'h00000000)
		else $error("empty stack read not aborted");

	chk_entry_newest: assert property (@(posedge mclk) disable iff (srst)
		(ce && err_push) ##1 (ce && rd && addr == {IDX_STACK, SUB_FIRST} && !err_push)
			|=> rdata == $past(new_entry, 2) && !resp_abort)
		else $error("entry 1 is not the newest error");

	chk_entry_pack: assert property (@(posedge mclk) disable iff (srst)
		(ce && err_push) |-> new_entry == ((32'(err_number) << ENT_NUMBER_LSB)
			| (32'(err_class) << ENT_CLASS_LSB) | 32'(err_code)))
		else $error("entry fields packed wrongly");

	chk_ro_refused: assert property (@(posedge mclk) disable iff (srst)
		(ce && wr && (sel_ident || sel_summary || sel_entry))
			|=> resp_abort && abort_code == ABORT_READ_ONLY)
		else $error("write to read-only object not refused");

	chk_irq_source: assert property (@(posedge mclk) disable iff (srst)
		(ce && err_push) |=> irq_status[IRQ_NEW_ERROR])
		else $error("new error did not raise status");

	cov_push_read: cover property (@(posedge mclk) disable iff (srst)
		(ce && err_push) ##[1:4] (ce && rd && sel_entry && !resp_abort));

	cov_overflow: cover property (@(posedge mclk) disable iff (srst)
		ce && irq_event[IRQ_DISCARD]);

	cov_clear_then_abort: cover property (@(posedge mclk) disable iff (srst)
		(ce && count_zero_wr) ##[1:4] (ce && rd && sel_entry) ##1 resp_abort);

	cov_irq: cover property (@(posedge mclk) disable iff (srst) $rose(irq));

endmodule : deb_bank

// *** verification/deb_master_model.sv ***
// fieldbus master model: one object access at a time over the register port
`timescale 1ns/100ps
module deb_master_model
	import deb_pkg::*;
(
	input  wire logic              mclk,
	output logic      [ADDR_W-1:0] addr,
	output logic      [31:0]       wdata,
	output logic                   wr,
	output logic                   rd,
	input  wire logic [31:0]       rdata,
	input  wire logic              resp_abort,
	input  wire logic [31:0]       abort_code
);
	initial begin
		addr  = '0;
		wdata = '0;
		wr    = 1'b0;
		rd    = 1'b0;
	end

	// ----------------------------------------------------------------
	// access: strobe one cycle, answer taken mid-cycle after the strobe
	// ----------------------------------------------------------------
	task automatic access(input logic is_wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		input int unsigned gap, output logic [31:0] q, output logic ab, output logic [31:0] code);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= is_wr;
		rd    <= !is_wr;
		@(posedge mclk);
		wr    <= 1'b0;
		rd    <= 1'b0;
		// released lines never echo the last value, so a late sample cannot pass by luck
		addr  <= ~a;
		wdata <= ~d;
		@(negedge mclk);
		q    = rdata;
		ab   = resp_abort;
		code = abort_code;
	endtask : access
endmodule : deb_master_model

// *** verification/tb_device_error_object_bank.sv ***
// testbench of the error object bank: identity, summary, history stack and interrupt
`timescale 1ns/100ps
module tb_device_error_object_bank;
	import deb_pkg::*;
	localparam logic [7:0]        TB_MOTOR   = MOTOR_STEPPER;
	// arbitrary profile number
	localparam logic [15:0]       TB_PROFILE = 16'h0123;
	localparam logic [ADDR_W-1:0] A_IDENT    = {IDX_IDENT, 8'h00};
	localparam logic [ADDR_W-1:0] A_SUM      = {IDX_SUMMARY, 8'h00};
	localparam logic [ADDR_W-1:0] A_CNT      = {IDX_STACK, 8'h00};
	localparam logic [ADDR_W-1:0] A_STAT     = {IDX_IRQ_STATUS, 8'h00};
	localparam logic [ADDR_W-1:0] A_MASK     = {IDX_IRQ_MASK, 8'h00};

	logic              mclk;
	logic              srst;
	logic              ce;
	logic [ADDR_W-1:0] addr;
	logic [31:0]       wdata;
	logic              wr;
	logic              rd;
	logic [31:0]       rdata;
	logic              resp_abort;
	logic [31:0]       abort_code;
	logic [7:0]        fault_active;
	logic              err_push;
	logic [7:0]        err_number;
	logic [7:0]        err_class;
	logic [15:0]       err_code;
	logic [7:0]        error_summary;
	logic              irq;
	int                n_errors;
	int                checks_done;
	int                exp_cnt;
	logic [31:0]       hist[$];

	initial mclk = 1'b0;
	always #10 mclk = ~mclk;

	deb_bank #(.MOTOR_TYPE(TB_MOTOR), .PROFILE_NUMBER(TB_PROFILE), .DEPTH(8)) DUT (
		.mclk(mclk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .resp_abort(resp_abort), .abort_code(abort_code), .fault_active(fault_active),
		.err_push(err_push), .err_number(err_number), .err_class(err_class), .err_code(err_code),
		.error_summary(error_summary), .irq(irq));

	deb_master_model master (
		.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .resp_abort(resp_abort), .abort_code(abort_code));

	// ----------------------------------------------------------------
	// expectations and helpers
	// ----------------------------------------------------------------
	function automatic logic [64:0] ok(input logic [31:0] q);
		ok = {1'b0, 32'h00000000, q};
	endfunction : ok

	function automatic logic [64:0] bad(input logic [31:0] c);
		bad = {1'b1, c, 32'h00000000};
	endfunction : bad

	// entries never pushed still hold their zero preset
	function automatic logic [64:0] exp_entry(input int sub);
		if (exp_cnt == 0) exp_entry = bad(ABORT_EMPTY);
		else if (sub > hist.size()) exp_entry = ok(32'h00000000);
		else exp_entry = ok(hist[sub-1]);
	endfunction : exp_entry

	task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic ex(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [64:0] e);
		logic [31:0] q;
		logic        ab;
		logic [31:0] c;
		master.access(w, a, d, $urandom_range(2, 0), q, ab, c);
		chk({ab, c, q}, e);
	endtask : ex

	task automatic check_stack;
		for (int s = 1; s <= 8; s++) ex(1'b0, {IDX_STACK, 8'(s)}, '0, exp_entry(s));
		ex(1'b0, A_CNT, '0, ok({24'h000000, 8'(exp_cnt)}));
	endtask : check_stack

	// back-to-back pushes of random errors
	task automatic push_n(input int n);
		logic [31:0] e;
		for (int i = 0; i < n; i++) begin
			@(posedge mclk);
			e = $urandom;
			err_push   <= 1'b1;
			err_number <= e[31:24];
			err_class  <= e[23:16];
			err_code   <= e[15:0];
			hist.push_front(e);
			if (hist.size() > 8) void'(hist.pop_back());
			if (exp_cnt < 255) exp_cnt++;
		end
		@(posedge mclk);
		err_push <= 1'b0;
	endtask : push_n

	// entry 1 read in the very cycle after the push edge
	task automatic push_then_read;
		logic [31:0] q;
		logic        ab;
		logic [31:0] c;
		fork
			push_n(1);
			master.access(1'b0, {IDX_STACK, SUB_FIRST}, '0, 1, q, ab, c);
		join
		chk({ab, c, q}, ok(hist[0]));
	endtask : push_then_read

	task automatic summary_step(input logic [7:0] v);
		@(posedge mclk);
		fault_active <= v;
		@(posedge mclk);
		@(negedge mclk);
		chk({57'h0, error_summary}, {57'h0, v & 8'hBF});
		ex(1'b0, A_SUM, '0, ok({24'h000000, v & 8'hBF}));
	endtask : summary_step

	task automatic close_out;
		$display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		srst         = 1'b1;
		ce           = 1'b1;
		fault_active = 8'h00;
		err_push     = 1'b0;
		err_number   = 8'h00;
		err_class    = 8'h00;
		err_code     = 16'h0000;
		n_errors     = 0;
		checks_done  = 0;
		exp_cnt      = 0;
		void'($urandom(13));
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		ex(1'b0, A_IDENT, '0, ok({8'h00, TB_MOTOR, TB_PROFILE}));
		ex(1'b0, A_SUM, '0, ok(32'h00000000));
		check_stack();
		ex(1'b1, A_IDENT, $urandom, bad(ABORT_READ_ONLY));
		ex(1'b1, A_SUM, 32'h000000FF, bad(ABORT_READ_ONLY));
		ex(1'b1, {IDX_STACK, 8'h08}, $urandom, bad(ABORT_READ_ONLY));
		ex(1'b0, A_IDENT, '0, ok({8'h00, TB_MOTOR, TB_PROFILE}));
		ex(1'b0, 24'h123400, '0, bad(ABORT_NO_OBJECT));
		ex(1'b1, 24'h123400, $urandom, bad(ABORT_NO_OBJECT));
		for (int i = 0; i < 24; i++) summary_step(i == 0 ? 8'hFF : i == 1 ? 8'h40 : i == 23 ? 8'h00 : 8'($urandom));
		push_n(3);
		push_then_read();
		check_stack();
		// a frozen block must ignore a push
		@(posedge mclk);
		ce       <= 1'b0;
		err_push <= 1'b1;
		@(posedge mclk);
		ce       <= 1'b1;
		err_push <= 1'b0;
		push_n(7);
		check_stack();
		ex(1'b1, A_CNT, 32'h00000005, bad(ABORT_BAD_VALUE));
		ex(1'b1, A_CNT, 32'h00000000, ok(32'h00000000));
		exp_cnt = 0;
		check_stack();
		// pushes past a full stack and rising summary bits have all left their mark
		ex(1'b0, A_STAT, '0, ok(32'h00000007));
		ex(1'b1, A_STAT, 32'h00000007, ok(32'h00000000));
		ex(1'b0, A_STAT, '0, ok(32'h00000000));
		push_n(1);
		ex(1'b0, A_STAT, '0, ok(32'h00000001));
		chk({64'h0, irq}, {64'h0, 1'b0});
		ex(1'b1, A_MASK, 32'h00000007, ok(32'h00000000));
		chk({64'h0, irq}, {64'h0, 1'b1});
		ex(1'b1, A_STAT, 32'h00000001, ok(32'h00000000));
		chk({64'h0, irq}, {64'h0, 1'b0});
		summary_step(8'h08);
		ex(1'b0, A_STAT, '0, ok(32'h00000004));
		chk({64'h0, irq}, {64'h0, 1'b1});
		summary_step(8'h00);
		ex(1'b1, A_STAT, 32'h00000004, ok(32'h00000000));
		chk({64'h0, irq}, {64'h0, 1'b0});
		check_stack();
		close_out();
	end

	// watchdog: the sequence needs well under 3000 cycles
	initial begin
		repeat (6000) @(posedge mclk);
		n_errors++;
		close_out();
	end
endmodule : tb_device_error_object_bank
